// *** src/acl_match_defines.svh ***
/*
 * Named constants for the access control entry matcher.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ACL_MATCH_DEFINES_SVH
`define ACL_MATCH_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_NH_VAL 12'h004
`define OFS_SRC_VAL 12'h008
`define OFS_SRC_MASK 12'h00C
`define OFS_ICMP 12'h010
`define OFS_STATUS 12'h014
`define OFS_HITS 12'h018

// ----------------------------------------------------------------
// control field positions and register reset values
// ----------------------------------------------------------------
`define CTRL_NH_LSB 0
`define CTRL_SRC_BIT 3
`define CTRL_HOP_LSB 4
`define CTRL_TYPE_BIT 6
`define CTRL_CODE_BIT 7
`define CTRL_ENABLE_BIT 8
`define CTRL_RESET 32'h0000_0000
`define NH_VAL_RESET 8'h00
`define SRC_VAL_RESET 32'h0000_0000
`define SRC_MASK_RESET 32'h0000_0000
`define ICMP_RESET 16'h0000

// ----------------------------------------------------------------
// protocol numbers and icmp field positions
// ----------------------------------------------------------------
`define PROTO_ICMPV6 8'h3A
`define PROTO_UDP 8'h11
`define PROTO_TCP 8'h06
`define ICMP_TYPE_LSB 0
`define ICMP_CODE_LSB 8

`endif

// *** src/acl_match_pkg.sv ***
/*
 * Types for the access control entry matcher.
 * Assumes nothing of its surroundings.
 */
package acl_match_pkg;
    typedef enum logic [2:0] {
        NH_ANY = 3'h0,
        NH_SPECIFIC = 3'h1,
        NH_ICMP = 3'h2,
        NH_UDP = 3'h3,
        NH_TCP = 3'h4
    } next_header_mode_t;

    typedef enum logic [1:0] {
        HOP_ANY = 2'h0,
        HOP_ZERO = 2'h1,
        HOP_NONZERO = 2'h2
    } hop_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EVAL = 3'b010,
        ST_DONE = 3'b100
    } match_state_t;
endpackage : acl_match_pkg

// *** src/entry_compare.sv ***
/*
 * Combinational compare of one frame header against one entry.
 * Assumes frame fields and settings stable while read.
 */
`timescale 1ns/10ps
`include "acl_match_defines.svh"

module entry_compare
    import acl_match_pkg::*;
#(
    parameter int ADDR_BITS = 32
) (
    // entry settings
    input wire next_header_mode_t nh_mode,
    input wire logic [7:0] nh_value,
    input wire logic source_address_criterion,
    input wire logic [ADDR_BITS-1:0] source_address_value,
    input wire logic [ADDR_BITS-1:0] source_address_mask,
    input wire hop_mode_t hop_mode,
    input wire logic type_specific,
    input wire logic [7:0] type_value,
    input wire logic code_specific,
    input wire logic [7:0] code_value,
    // frame fields
    input wire logic [7:0] frm_next_header,
    input wire logic [ADDR_BITS-1:0] frm_src_low,
    input wire logic [7:0] frm_hop_limit,
    input wire logic [7:0] frm_icmp_type,
    input wire logic [7:0] frm_icmp_code,
    // result
    output logic hit
);
    initial begin
        if (ADDR_BITS != 32) $error("entry_compare: ADDR_BITS must be 32");
    end

    function automatic logic field_ok(input logic specific, input logic [7:0] want,
                                      input logic [7:0] got);
        field_ok = !specific || (want == got);
    endfunction : field_ok

    logic nh_ok;
    logic src_ok;
    logic hop_ok;
    logic icmp_ok;

    always_comb begin
        nh_ok = 1'b1;
        icmp_ok = 1'b1;
        unique case (nh_mode)
            NH_ANY: nh_ok = 1'b1;
            NH_SPECIFIC: nh_ok = (frm_next_header == nh_value);
            NH_ICMP: begin
                nh_ok = (frm_next_header == `PROTO_ICMPV6);
                icmp_ok = field_ok(type_specific, type_value, frm_icmp_type)
                    && field_ok(code_specific, code_value, frm_icmp_code);
            end
            NH_UDP: nh_ok = (frm_next_header == `PROTO_UDP);
            NH_TCP: nh_ok = (frm_next_header == `PROTO_TCP);
            default: nh_ok = 1'b0;
        endcase
    end

    // only the low word of the source address is seen here
    assign src_ok = !source_address_criterion
        || ((frm_src_low & source_address_mask)
            == (source_address_value & source_address_mask));

    always_comb begin
        unique case (hop_mode)
            HOP_ANY: hop_ok = 1'b1;
            HOP_ZERO: hop_ok = (frm_hop_limit == 8'h00);
            HOP_NONZERO: hop_ok = (frm_hop_limit != 8'h00);
            default: hop_ok = 1'b0;
        endcase
    end

    assign hit = nh_ok && src_ok && hop_ok && icmp_ok;
endmodule : entry_compare

// *** src/acl_entry_matcher.sv ***
/*
 * One IPv6 access control entry with APB settings and a frame port.
 * Assumes one clock, synchronous reset, frame fields from core logic.
 */
`timescale 1ns/10ps
`include "acl_match_defines.svh"

module acl_entry_matcher
    import acl_match_pkg::*;
#(
    parameter int ADDR_BITS = 32,
    parameter int HIT_BITS = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ingress frame header
    input wire logic frm_valid,
    input wire logic [7:0] frm_next_header,
    input wire logic [127:0] frm_src_addr,
    input wire logic [7:0] frm_hop_limit,
    input wire logic [7:0] frm_icmp_type,
    input wire logic [7:0] frm_icmp_code,
    // match result
    output logic result_valid,
    output logic result_hit
);
    initial begin
        if (ADDR_BITS != 32) $error("acl_entry_matcher: ADDR_BITS must be 32");
        if (HIT_BITS < 1 || HIT_BITS > 32) $error("acl_entry_matcher: bad HIT_BITS");
    end

    // ----------------------------------------------------------------
    // settings registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [7:0] nh_value_reg;
    logic [ADDR_BITS-1:0] src_value_reg;
    logic [ADDR_BITS-1:0] src_mask_reg;
    logic [15:0] icmp_reg;
    logic [HIT_BITS-1:0] hits_reg;
    logic [HIT_BITS-1:0] hits_next;
    logic last_hit_reg;

    // ----------------------------------------------------------------
    // bus decode and response
    // ----------------------------------------------------------------
    logic wr_access;
    logic rd_access;
    logic addr_known;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `OFS_CTRL) || (a == `OFS_NH_VAL) || (a == `OFS_SRC_VAL)
            || (a == `OFS_SRC_MASK) || (a == `OFS_ICMP) || (a == `OFS_STATUS)
            || (a == `OFS_HITS);
    endfunction : is_mapped

    assign addr_known = is_mapped(paddr);
    assign wr_access = psel && penable && pwrite && addr_known;
    assign rd_access = psel && !pwrite;
    // zero wait states: every access ends in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_known;

    // ----------------------------------------------------------------
    // write strobes, one per writable register
    // ----------------------------------------------------------------
    logic wr_ctrl;
    logic wr_nh_value;
    logic wr_src_value;
    logic wr_src_mask;
    logic wr_icmp;

    // status and hit counter are read-only: no strobe
    assign wr_ctrl = wr_access && (paddr == `OFS_CTRL);
    assign wr_nh_value = wr_access && (paddr == `OFS_NH_VAL);
    assign wr_src_value = wr_access && (paddr == `OFS_SRC_VAL);
    assign wr_src_mask = wr_access && (paddr == `OFS_SRC_MASK);
    assign wr_icmp = wr_access && (paddr == `OFS_ICMP);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= pwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            nh_value_reg <= `NH_VAL_RESET;
        end else if (wr_nh_value) begin
            nh_value_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            src_value_reg <= ADDR_BITS'(`SRC_VAL_RESET);
        end else if (wr_src_value) begin
            src_value_reg <= pwdata[ADDR_BITS-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            src_mask_reg <= ADDR_BITS'(`SRC_MASK_RESET);
        end else if (wr_src_mask) begin
            src_mask_reg <= pwdata[ADDR_BITS-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            icmp_reg <= `ICMP_RESET;
        end else if (wr_icmp) begin
            icmp_reg <= pwdata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [31:0] rd_word;

    always_comb begin
        unique case (paddr)
            `OFS_CTRL: rd_word = ctrl_reg;
            `OFS_NH_VAL: rd_word = {24'h00_0000, nh_value_reg};
            `OFS_SRC_VAL: rd_word = src_value_reg;
            `OFS_SRC_MASK: rd_word = src_mask_reg;
            `OFS_ICMP: rd_word = {16'h0000, icmp_reg};
            `OFS_STATUS: rd_word = {31'h0000_0000, last_hit_reg};
            `OFS_HITS: rd_word = 32'(hits_reg);
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // loaded at setup so it stands through the access phase
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_access && !penable) begin
            prdata <= rd_word;
        end
    end

    // ----------------------------------------------------------------
    // decoded settings
    // ----------------------------------------------------------------
    next_header_mode_t nh_mode;
    hop_mode_t hop_mode;
    logic entry_enable;

    // unused codes of both fields fall back to any
    always_comb begin
        unique case (ctrl_reg[`CTRL_NH_LSB +: 3])
            3'h1: nh_mode = NH_SPECIFIC;
            3'h2: nh_mode = NH_ICMP;
            3'h3: nh_mode = NH_UDP;
            3'h4: nh_mode = NH_TCP;
            default: nh_mode = NH_ANY;
        endcase
        unique case (ctrl_reg[`CTRL_HOP_LSB +: 2])
            2'h1: hop_mode = HOP_ZERO;
            2'h2: hop_mode = HOP_NONZERO;
            default: hop_mode = HOP_ANY;
        endcase
    end
    assign entry_enable = ctrl_reg[`CTRL_ENABLE_BIT];

    // ----------------------------------------------------------------
    // frame capture and compare
    // ----------------------------------------------------------------
    logic [7:0] cap_nh_reg;
    logic [ADDR_BITS-1:0] cap_src_reg;
    logic [7:0] cap_hop_reg;
    logic [7:0] cap_type_reg;
    logic [7:0] cap_code_reg;
    logic cmp_hit;
    match_state_t state_reg;
    logic frm_take;

    // a frame refused during eval must not disturb the capture
    assign frm_take = frm_valid && (state_reg != ST_EVAL);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cap_nh_reg <= 8'h00;
            cap_src_reg <= '0;
            cap_hop_reg <= 8'h00;
            cap_type_reg <= 8'h00;
            cap_code_reg <= 8'h00;
        end else if (frm_take) begin
            cap_nh_reg <= frm_next_header;
            cap_src_reg <= frm_src_addr[ADDR_BITS-1:0];
            cap_hop_reg <= frm_hop_limit;
            cap_type_reg <= frm_icmp_type;
            cap_code_reg <= frm_icmp_code;
        end
    end

    entry_compare #(
        .ADDR_BITS(ADDR_BITS)
    ) u_compare (
        .nh_mode(nh_mode),
        .nh_value(nh_value_reg),
        .source_address_criterion(ctrl_reg[`CTRL_SRC_BIT]),
        .source_address_value(src_value_reg),
        .source_address_mask(src_mask_reg),
        .hop_mode(hop_mode),
        .type_specific(ctrl_reg[`CTRL_TYPE_BIT]),
        .type_value(icmp_reg[`ICMP_TYPE_LSB +: 8]),
        .code_specific(ctrl_reg[`CTRL_CODE_BIT]),
        .code_value(icmp_reg[`ICMP_CODE_LSB +: 8]),
        .frm_next_header(cap_nh_reg),
        .frm_src_low(cap_src_reg),
        .frm_hop_limit(cap_hop_reg),
        .frm_icmp_type(cap_type_reg),
        .frm_icmp_code(cap_code_reg),
        .hit(cmp_hit)
    );

    // ----------------------------------------------------------------
    // sequencing: capture, evaluate, present
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (frm_valid) state_reg <= ST_EVAL;
                ST_EVAL: state_reg <= ST_DONE;
                ST_DONE: state_reg <= frm_valid ? ST_EVAL : ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // hit of the frame under evaluation, gated by the entry enable
    logic eval_hit;

    assign eval_hit = (state_reg == ST_EVAL) && entry_enable && cmp_hit;

    // frames arriving in eval are dropped; one frame per two cycles
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            result_valid <= 1'b0;
            result_hit <= 1'b0;
        end else begin
            result_valid <= (state_reg == ST_EVAL);
            result_hit <= eval_hit;
        end
    end

    // ----------------------------------------------------------------
    // statistics
    // ----------------------------------------------------------------
    assign hits_next = hits_reg + HIT_BITS'(1);

    // counts every hit of the entry, wraps at the top
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hits_reg <= '0;
        end else if (eval_hit) begin
            hits_reg <= hits_next;
        end
    end

    // outcome of the most recent frame, hit or miss
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            last_hit_reg <= 1'b0;
        end else if (state_reg == ST_EVAL) begin
            last_hit_reg <= eval_hit;
        end
    end
endmodule : acl_entry_matcher

// *** tb/acl_entry_matcher_monitor.sv ***
/* port checker for the entry matcher.
   assumes it is bound onto acl_entry_matcher. */
`timescale 1ns/10ps
module acl_entry_matcher_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // frame and result
    input wire logic frm_valid,
    input wire logic result_valid,
    input wire logic result_hit
);
    logic acc;
    assign acc = psel && penable;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----
    // assertions
    // ----
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_frame_latency: assert property (frm_valid |-> ##2 result_valid)
        else $error("result not two cycles after frame");
    chk_result_pulse: assert property (result_valid |=> !result_valid)
        else $error("result longer than one cycle");
    chk_hit_qualified: assert property (result_hit |-> result_valid)
        else $error("hit without result");
    chk_result_cause: assert property (result_valid |-> $past(frm_valid, 2))
        else $error("result without frame");
    chk_unmapped_err: assert property (acc && paddr > 12'h018 |-> pslverr)
        else $error("no error on unmapped address");
    chk_mapped_ok: assert property (acc && paddr <= 12'h018 && paddr[1:0] == 2'b00
        |-> !pslverr)
        else $error("error on mapped address");
    chk_err_rdata: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read data not zero");
    chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    cov_hit: cover property (result_valid && result_hit);
    cov_miss: cover property (result_valid && !result_hit);
    cov_err: cover property (acc && pslverr);
endmodule : acl_entry_matcher_monitor

bind acl_entry_matcher acl_entry_matcher_monitor u_mon (.clk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .frm_valid, .result_valid, .result_hit);

// *** tb/frame_source.sv ***
/* ingress frame header source.
   assumes the bench calls send with at least one idle cycle between. */
`timescale 1ns/10ps
module frame_source (
    // clock
    input wire logic clk,
    // frame header
    output logic frm_valid,
    output logic [7:0] frm_next_header,
    output logic [127:0] frm_src_addr,
    output logic [7:0] frm_hop_limit,
    output logic [7:0] frm_icmp_type,
    output logic [7:0] frm_icmp_code
);
    initial begin
        frm_valid = 1'b0;
        {frm_next_header, frm_src_addr, frm_hop_limit, frm_icmp_type, frm_icmp_code} = '0;
    end
    // one-cycle header, then fields scrambled so stale values never match
    task automatic send(input logic [7:0] n, input logic [127:0] s, input logic [7:0] h,
        input logic [7:0] t, input logic [7:0] c);
        @(posedge clk);
        frm_valid <= 1'b1;
        {frm_next_header, frm_src_addr, frm_hop_limit, frm_icmp_type, frm_icmp_code} <=
            {n, s, h, t, c};
        @(posedge clk);
        frm_valid <= 1'b0;
        {frm_next_header, frm_src_addr, frm_hop_limit, frm_icmp_type, frm_icmp_code} <=
            ~{n, s, h, t, c};
    endtask : send
endmodule : frame_source

// *** tb/testbench.sv ***
/* self-checking bench for the entry matcher.
   assumes frame_source and the bound monitor. */
`timescale 1ns/10ps
`include "acl_match_defines.svh"
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin \
    n_mismatch++; $display("MISMATCH %0t %s", $time, m); end end
module testbench
    import acl_match_pkg::*;
;
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic frm_valid, result_valid, result_hit;
    logic [7:0] frm_next_header, frm_hop_limit, frm_icmp_type, frm_icmp_code;
    logic [127:0] frm_src_addr;
    int n_mismatch = 0, tests_run = 0, cycles = 0, exp_hits = 0;
    acl_entry_matcher u_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .frm_valid, .frm_next_header, .frm_src_addr,
        .frm_hop_limit, .frm_icmp_type, .frm_icmp_code, .result_valid, .result_hit);
    frame_source u_src (.clk, .frm_valid, .frm_next_header, .frm_src_addr,
        .frm_hop_limit, .frm_icmp_type, .frm_icmp_code);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            final_report();
        end
    end
    // ----
    // bus and frame helpers
    // ----
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e, "read data")
        `CHK(err, 1'b0, "read error")
    endtask : rchk
    task automatic cfg(input logic [31:0] c);
        apb(1'b1, `OFS_CTRL, c | (32'h0000_0001 << `CTRL_ENABLE_BIT));
    endtask : cfg
    task automatic frm(input logic e, input logic [7:0] n = 8'h3A,
        input logic [31:0] s = 32'h0000_0003, input logic [7:0] h = 8'h40,
        input logic [7:0] t = 8'h80, input logic [7:0] c = 8'h00);
        u_src.send(n, {{3{~s}}, s}, h, t, c);
        for (int i = 0; i < 4 && result_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        `CHK(result_valid, 1'b1, "no result")
        `CHK(result_hit, e, "hit")
        exp_hits += int'(e);
    endtask : frm
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        rchk(`OFS_CTRL, `CTRL_RESET);
        apb(1'b1, `OFS_NH_VAL, 32'hFFFF_FF5A);
        rchk(`OFS_NH_VAL, 32'h0000_005A);
        apb(1'b1, `OFS_STATUS, 32'hFFFF_FFFF);
        rchk(`OFS_STATUS, 32'h0000_0000);
        apb(1'b0, 12'h01C, 32'h0000_0000);
        `CHK(err, 1'b1, "unmapped error")
        `CHK(rd, 32'h0000_0000, "unmapped read data")
        $display("test regs done");
    endtask : t_regs
    task automatic t_nh();
        apb(1'b1, `OFS_NH_VAL, 32'h0000_00FF);
        cfg(32'(NH_ANY));
        frm(1'b1, 8'h99);
        cfg(32'(NH_SPECIFIC));
        frm(1'b1, 8'hFF);
        rchk(`OFS_STATUS, 32'h0000_0001);
        frm(1'b0, 8'hFE);
        apb(1'b1, `OFS_NH_VAL, 32'h0000_0000);
        frm(1'b1, 8'h00);
        frm(1'b0, 8'h01);
        apb(1'b1, `OFS_CTRL, 32'(NH_ANY));
        frm(1'b0);
        $display("test next header done");
    endtask : t_nh
    task automatic t_proto();
        logic [7:0] p [3] = '{`PROTO_ICMPV6, `PROTO_UDP, `PROTO_TCP};
        for (int i = 0; i < 3; i++) begin
            cfg(32'(NH_ICMP) + 32'(i));
            frm(1'b1, p[i]);
            frm(1'b0, p[(i + 1) % 3]);
        end
        cfg(32'(NH_UDP) | 32'h0000_00C0);
        frm(1'b1, `PROTO_UDP, 32'h0000_0003, 8'h40, 8'h12, 8'h34);
        $display("test protocol done");
    endtask : t_proto
    task automatic t_src();
        apb(1'b1, `OFS_SRC_VAL, 32'h0000_0003);
        apb(1'b1, `OFS_SRC_MASK, 32'hFFFF_FFFE);
        cfg(32'h0000_0000);
        frm(1'b1, 8'h3A, 32'h1234_5678);
        cfg(32'h0000_0001 << `CTRL_SRC_BIT);
        frm(1'b1, 8'h3A, 32'h0000_0002);
        frm(1'b1, 8'h3A, 32'h0000_0003);
        frm(1'b0, 8'h3A, 32'h0000_0001);
        frm(1'b0, 8'h3A, 32'h8000_0003);
        $display("test source done");
    endtask : t_src
    task automatic t_hop();
        cfg(32'(HOP_ZERO) << `CTRL_HOP_LSB);
        frm(1'b0, 8'h3A, 32'h0000_0003, 8'h01);
        frm(1'b1, 8'h3A, 32'h0000_0003, 8'h00);
        cfg(32'(HOP_NONZERO) << `CTRL_HOP_LSB);
        frm(1'b1, 8'h3A, 32'h0000_0003, 8'hFF);
        cfg(32'(HOP_ANY) << `CTRL_HOP_LSB);
        frm(1'b1, 8'h3A, 32'h0000_0003, 8'h00);
        frm(1'b1, 8'h3A, 32'h0000_0003, 8'hFF);
        cfg(32'h0000_0037);
        frm(1'b1, 8'h99, 32'h0000_0003, 8'h00);
        $display("test hop done");
    endtask : t_hop
    task automatic t_icmp();
        apb(1'b1, `OFS_ICMP, 32'h0000_0080);
        cfg(32'(NH_ICMP) | 32'h0000_00C0);
        frm(1'b1, 8'h3A, 32'h0000_0003, 8'h40, 8'h80, 8'h00);
        frm(1'b0, 8'h3A, 32'h0000_0003, 8'h40, 8'h81, 8'h00);
        frm(1'b0, 8'h3A, 32'h0000_0003, 8'h40, 8'h80, 8'h01);
        apb(1'b1, `OFS_ICMP, 32'h0000_FFFF);
        frm(1'b1, 8'h3A, 32'h0000_0003, 8'h40, 8'hFF, 8'hFF);
        cfg(32'(NH_ICMP) | 32'h0000_0048);
        frm(1'b1, 8'h3A, 32'h0000_0003, 8'h40, 8'hFF, 8'h12);
        frm(1'b0, 8'h3A, 32'h0000_0001, 8'h40, 8'hFF, 8'h12);
        rchk(`OFS_HITS, 32'(exp_hits));
        rchk(`OFS_STATUS, 32'h0000_0000);
        $display("test icmp done");
    endtask : t_icmp
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_nh();
        t_proto();
        t_src();
        t_hop();
        t_icmp();
        final_report();
    end
endmodule : testbench
